// file: core/sfpes_params.svh
`ifndef SFPES_PARAMS_SVH
`define SFPES_PARAMS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFPES_OP_BUF1_WRITE 8'h84
`define SFPES_OP_BUF2_WRITE 8'h87
`define SFPES_OP_BUF1_PROG_ERASE 8'h83
`define SFPES_OP_BUF2_PROG_ERASE 8'h86
`define SFPES_OP_BUF1_PROG_NOERASE 8'h88
`define SFPES_OP_BUF2_PROG_NOERASE 8'h89
`define SFPES_OP_PAGE_ERASE 8'h81
`define SFPES_OP_BLOCK_ERASE 8'h50
`define SFPES_OP_BUF1_PROG_THRU 8'h82
`define SFPES_OP_BUF2_PROG_THRU 8'h85
`define SFPES_OP_BUF1_XFER 8'h53
`define SFPES_OP_BUF2_XFER 8'h55
`define SFPES_OP_BUF1_COMPARE 8'h60
`define SFPES_OP_BUF2_COMPARE 8'h61
`define SFPES_OP_BUF1_REWRITE 8'h58
`define SFPES_OP_BUF2_REWRITE 8'h59
`define SFPES_OP_STATUS 8'h57
// ----------------------------------------
// Status byte fields and header layout
// ----------------------------------------
`define SFPES_STAT_READY_BIT 7
`define SFPES_STAT_COMP_BIT 6
`define SFPES_HDR_BYTES 4
`define SFPES_BLOCK_SHIFT 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SFPES_CLK_NS 10
`define SFPES_SCK_HALF_NS 40
`define SFPES_SCK_HALF_CYCLES ((`SFPES_SCK_HALF_NS + `SFPES_CLK_NS - 1) / `SFPES_CLK_NS)
`define SFPES_CS_HIGH_NS 250
`define SFPES_CS_HIGH_CYCLES ((`SFPES_CS_HIGH_NS + `SFPES_CLK_NS - 1) / `SFPES_CLK_NS)
// ----------------------------------------
// Wear levelling of sectors
// ----------------------------------------
`define SFPES_REWRITE_LIMIT 10000
`define SFPES_MAX_SECTOR_PAGES 512
`define SFPES_REWRITE_INTERVAL (`SFPES_REWRITE_LIMIT / `SFPES_MAX_SECTOR_PAGES - 1)
`define SFPES_SECTOR_COUNT 4
`endif

// file: core/sfpes_pkg.sv
package sfpes_pkg;
  // Commands the host can issue
  typedef enum logic [3:0] {
    cmd_buf_write = 4'h0,
    cmd_prog_erase = 4'h1,
    cmd_prog_noerase = 4'h2,
    cmd_page_erase = 4'h3,
    cmd_block_erase = 4'h4,
    cmd_prog_thru_buf = 4'h5,
    cmd_xfer = 4'h6,
    cmd_compare = 4'h7,
    cmd_rewrite = 4'h8
  } sfpes_cmd_t;
  // Sequencer states
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_poll_cmd = 7'h02,
    st_poll_rd = 7'h04,
    st_hdr = 7'h08,
    st_data = 7'h10,
    st_gap = 7'h20,
    st_fin = 7'h40
  } sfpes_state_t;
endpackage

// file: core/sfpes_shifter.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfpes_params.svh"
module sfpes_shifter #(
  parameter int SCK_HALF = `SFPES_SCK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Byte request
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic done,
  output logic [7:0] rx_byte,
  // Serial pins
  output logic sck,
  output logic si,
  input wire logic so
);
  logic active_reg;
  logic [7:0] half_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic sck_reg;
  logic si_reg;
  logic done_reg;
  logic so_meta_reg;
  logic so_sync_reg;
  logic half_tick;

  // Two-stage synchroniser for the serial output pin
  always_ff @(posedge sys_clk)
  begin
    so_meta_reg <= so;
    so_sync_reg <= so_meta_reg;
  end

  assign half_tick = active_reg && (half_cnt_reg == 8'(SCK_HALF - 1));

  // Half-period divider of the serial clock
  always_ff @(posedge sys_clk)
  begin
    if (reset || !active_reg || half_tick)
      half_cnt_reg <= 8'h00;
    else
      half_cnt_reg <= half_cnt_reg + 8'h01;
  end

  // Mode 0 bit engine: MSB first, SI set while SCK low, SO taken at SCK fall
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      active_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start && !active_reg)
      begin
        active_reg <= 1'b1;
        tx_reg <= tx_byte;
        si_reg <= tx_byte[7];
        bit_cnt_reg <= 3'h0;
        sck_reg <= 1'b0;
      end
      else if (half_tick)
      begin
        if (!sck_reg)
          sck_reg <= 1'b1;
        else
        begin
          sck_reg <= 1'b0;
          rx_reg <= {rx_reg[6:0], so_sync_reg};
          if (bit_cnt_reg == 3'h7)
          begin
            active_reg <= 1'b0;
            done_reg <= 1'b1;
          end
          else
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            si_reg <= tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  assign done = done_reg;
  assign rx_byte = rx_reg;
  assign sck = sck_reg;
  assign si = si_reg;
endmodule // sfpes_shifter
`default_nettype wire

// file: core/sfpes_wear.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfpes_params.svh"
module sfpes_wear #(
  parameter int INTERVAL = `SFPES_REWRITE_INTERVAL
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Completed array write operations
  input wire logic op_done,
  input wire logic [9:0] op_page,
  // Refresh request
  input wire logic taken,
  output logic due,
  output logic [9:0] due_page
);
  localparam int NS = `SFPES_SECTOR_COUNT;
  logic [15:0] cnt_reg [NS];
  logic [9:0] ptr_reg [NS];
  logic [NS-1:0] due_vec;
  logic [1:0] sel;

  // Sector of a page
  function automatic logic [1:0] sector_of(input logic [9:0] p);
    if (p < 10'h008)
      return 2'h0;
    else if (p < 10'h100)
      return 2'h1;
    else if (p < 10'h200)
      return 2'h2;
    else
      return 2'h3;
  endfunction

  // First page and last page offset of a sector
  function automatic logic [9:0] sector_base(input logic [1:0] s);
    case (s)
      2'h0: return 10'h000;
      2'h1: return 10'h008;
      2'h2: return 10'h100;
      default: return 10'h200;
    endcase
  endfunction

  function automatic logic [9:0] sector_last(input logic [1:0] s);
    case (s)
      2'h0: return 10'h007;
      2'h1: return 10'h0f7;
      2'h2: return 10'h0ff;
      default: return 10'h1ff;
    endcase
  endfunction

  // Per-sector operation counter and round-robin refresh pointer
  for (genvar g = 0; g < NS; g++)
  begin : g_sector
    logic hit;
    logic take;
    assign hit = op_done && (sector_of(op_page) == 2'(g));
    assign take = taken && (sel == 2'(g));
    always_ff @(posedge sys_clk)
    begin
      if (reset)
      begin
        cnt_reg[g] <= 16'h0000;
        ptr_reg[g] <= 10'h000;
      end
      else
      begin
        if (take)
        begin
          cnt_reg[g] <= {15'h0000, hit};
          if (ptr_reg[g] == sector_last(2'(g)))
            ptr_reg[g] <= 10'h000;
          else
            ptr_reg[g] <= ptr_reg[g] + 10'h001;
        end
        else if (hit && (cnt_reg[g] != 16'hffff))
          cnt_reg[g] <= cnt_reg[g] + 16'h0001;
      end
    end
    assign due_vec[g] = cnt_reg[g] >= 16'(INTERVAL);
  end

  // Lowest-numbered sector that needs a refresh
  always_comb
  begin
    sel = 2'h0;
    for (int i = NS - 1; i >= 0; i--)
      if (due_vec[i])
        sel = 2'(i);
  end

  assign due = |due_vec;
  assign due_page = sector_base(sel) + ptr_reg[sel];
endmodule // sfpes_wear
`default_nettype wire

// file: core/sfpes_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "sfpes_params.svh"
module sfpes_host #(
  parameter int SCK_HALF = `SFPES_SCK_HALF_CYCLES,
  parameter int CS_HIGH = `SFPES_CS_HIGH_CYCLES,
  parameter int REWRITE_INTERVAL = `SFPES_REWRITE_INTERVAL
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sfpes_pkg::sfpes_cmd_t cmd_op,
  input wire logic cmd_buffer_two,
  input wire logic [9:0] cmd_page_number,
  input wire logic [8:0] cmd_buffer_byte_index,
  // Buffer load data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  input wire logic wr_last,
  // Status
  output logic busy,
  output logic done,
  output logic compare_mismatch,
  output logic [7:0] status_byte,
  output logic rewrite_active,
  // Flash pins
  output logic flash_cs_n,
  output logic flash_sck,
  output logic flash_si,
  input wire logic flash_so
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sfpes_pkg::sfpes_state_t state_reg;
  sfpes_pkg::sfpes_state_t gap_next_reg;
  sfpes_pkg::sfpes_cmd_t op_reg;
  logic buf2_reg;
  logic [9:0] page_reg;
  logic [8:0] bfa_reg;
  logic post_reg;
  logic [1:0] byte_idx_reg;
  logic in_flight_reg;
  logic last_reg;
  logic [7:0] gap_cnt_reg;
  logic cs_n_reg;
  logic done_reg;
  logic mismatch_reg;
  logic [7:0] status_reg;
  logic rewrite_reg;
  logic sh_start;
  logic [7:0] sh_tx;
  logic sh_done;
  logic [7:0] sh_rx;
  logic wear_due;
  logic [9:0] wear_page;
  logic wear_taken;
  logic wear_op_done;
  logic [31:0] hdr;

  // ----------------------------------------
  // Command decoding
  // ----------------------------------------

  // Commands that occupy the main array
  function automatic logic uses_array(input sfpes_pkg::sfpes_cmd_t op);
    return op != sfpes_pkg::cmd_buf_write;
  endfunction

  // Commands that erase or program the array
  function automatic logic writes_array(input sfpes_pkg::sfpes_cmd_t op);
    return !(op inside {sfpes_pkg::cmd_buf_write, sfpes_pkg::cmd_xfer,
                        sfpes_pkg::cmd_compare});
  endfunction

  // Commands followed by buffer data bytes
  function automatic logic has_data(input sfpes_pkg::sfpes_cmd_t op);
    return op inside {sfpes_pkg::cmd_buf_write, sfpes_pkg::cmd_prog_thru_buf};
  endfunction

  // Opcode and 24-bit address of a command
  function automatic logic [31:0] hdr_word(input sfpes_pkg::sfpes_cmd_t op,
                                           input logic b2,
                                           input logic [9:0] pg,
                                           input logic [8:0] bfa);
    logic [7:0] opc;
    logic [23:0] adr;
    opc = 8'h00;
    adr = {5'h00, pg, 9'h000};
    case (op)
      sfpes_pkg::cmd_buf_write:
      begin
        opc = b2 ? `SFPES_OP_BUF2_WRITE : `SFPES_OP_BUF1_WRITE;
        adr = {15'h0000, bfa};
      end
      sfpes_pkg::cmd_prog_erase:
        opc = b2 ? `SFPES_OP_BUF2_PROG_ERASE : `SFPES_OP_BUF1_PROG_ERASE;
      sfpes_pkg::cmd_prog_noerase:
        opc = b2 ? `SFPES_OP_BUF2_PROG_NOERASE : `SFPES_OP_BUF1_PROG_NOERASE;
      sfpes_pkg::cmd_page_erase:
        opc = `SFPES_OP_PAGE_ERASE;
      sfpes_pkg::cmd_block_erase:
      begin
        opc = `SFPES_OP_BLOCK_ERASE;
        adr = {5'h00, pg[9:`SFPES_BLOCK_SHIFT], 12'h000};
      end
      sfpes_pkg::cmd_prog_thru_buf:
      begin
        opc = b2 ? `SFPES_OP_BUF2_PROG_THRU : `SFPES_OP_BUF1_PROG_THRU;
        adr = {5'h00, pg, bfa};
      end
      sfpes_pkg::cmd_xfer:
        opc = b2 ? `SFPES_OP_BUF2_XFER : `SFPES_OP_BUF1_XFER;
      sfpes_pkg::cmd_compare:
        opc = b2 ? `SFPES_OP_BUF2_COMPARE : `SFPES_OP_BUF1_COMPARE;
      default:
        opc = b2 ? `SFPES_OP_BUF2_REWRITE : `SFPES_OP_BUF1_REWRITE;
    endcase
    return {opc, adr};
  endfunction

  assign hdr = hdr_word(op_reg, buf2_reg, page_reg, bfa_reg);

  // ----------------------------------------
  // Byte requests to the serial engine
  // ----------------------------------------

  // Start the next byte of the current phase
  always_comb
  begin
    sh_start = 1'b0;
    sh_tx = 8'h00;
    case (state_reg)
      sfpes_pkg::st_poll_cmd:
      begin
        sh_start = !in_flight_reg;
        sh_tx = `SFPES_OP_STATUS;
      end
      sfpes_pkg::st_poll_rd:
        sh_start = !in_flight_reg;
      sfpes_pkg::st_hdr:
      begin
        sh_start = !in_flight_reg;
        sh_tx = hdr[8 * (3 - byte_idx_reg) +: 8];
      end
      sfpes_pkg::st_data:
      begin
        sh_start = !in_flight_reg && wr_valid;
        sh_tx = wr_data;
      end
      default:
        sh_start = 1'b0;
    endcase
  end

  assign wr_ready = (state_reg == sfpes_pkg::st_data) && !in_flight_reg;
  assign cmd_ready = (state_reg == sfpes_pkg::st_idle) && !wear_due;
  assign wear_taken = (state_reg == sfpes_pkg::st_idle) && wear_due;
  assign wear_op_done = (state_reg == sfpes_pkg::st_fin) && writes_array(op_reg);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------

  // Command, poll and chip select phases
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= sfpes_pkg::st_idle;
      gap_next_reg <= sfpes_pkg::st_idle;
      op_reg <= sfpes_pkg::cmd_buf_write;
      buf2_reg <= 1'b0;
      page_reg <= 10'h000;
      bfa_reg <= 9'h000;
      post_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
      gap_cnt_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        sfpes_pkg::st_idle:
        begin
          byte_idx_reg <= 2'h0;
          post_reg <= 1'b0;
          if (wear_due)
          begin
            op_reg <= sfpes_pkg::cmd_rewrite;
            buf2_reg <= 1'b0;
            page_reg <= wear_page;
            state_reg <= sfpes_pkg::st_poll_cmd;
          end
          else if (cmd_valid)
          begin
            op_reg <= cmd_op;
            buf2_reg <= cmd_buffer_two;
            page_reg <= cmd_page_number;
            bfa_reg <= cmd_buffer_byte_index;
            if (uses_array(cmd_op))
              state_reg <= sfpes_pkg::st_poll_cmd;
            else
              state_reg <= sfpes_pkg::st_hdr;
          end
        end
        sfpes_pkg::st_poll_cmd:
          if (sh_done)
            state_reg <= sfpes_pkg::st_poll_rd;
        sfpes_pkg::st_poll_rd:
          if (sh_done && sh_rx[`SFPES_STAT_READY_BIT])
          begin
            state_reg <= sfpes_pkg::st_gap;
            gap_next_reg <= post_reg ? sfpes_pkg::st_fin : sfpes_pkg::st_hdr;
          end
        sfpes_pkg::st_hdr:
          if (sh_done)
          begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
            if (byte_idx_reg == 2'(`SFPES_HDR_BYTES - 1))
            begin
              if (has_data(op_reg))
                state_reg <= sfpes_pkg::st_data;
              else
              begin
                state_reg <= sfpes_pkg::st_gap;
                gap_next_reg <= sfpes_pkg::st_poll_cmd;
                post_reg <= 1'b1;
              end
            end
          end
        sfpes_pkg::st_data:
          if (sh_done && last_reg)
          begin
            state_reg <= sfpes_pkg::st_gap;
            gap_next_reg <= uses_array(op_reg) ? sfpes_pkg::st_poll_cmd
                                               : sfpes_pkg::st_fin;
            post_reg <= uses_array(op_reg);
          end
        sfpes_pkg::st_gap:
        begin
          gap_cnt_reg <= gap_cnt_reg + 8'h01;
          if (gap_cnt_reg == 8'(CS_HIGH - 1))
          begin
            gap_cnt_reg <= 8'h00;
            state_reg <= gap_next_reg;
          end
        end
        default:
          state_reg <= sfpes_pkg::st_idle;
      endcase
    end
  end

  // Byte in flight and last-data marker
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      in_flight_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      if (sh_start)
        in_flight_reg <= 1'b1;
      else if (sh_done)
        in_flight_reg <= 1'b0;
      if (sh_start && (state_reg == sfpes_pkg::st_data))
        last_reg <= wr_last;
    end
  end

  // Chip select stays low from first to last bit of a frame
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cs_n_reg <= 1'b1;
    else
      cs_n_reg <= state_reg inside {sfpes_pkg::st_idle, sfpes_pkg::st_gap,
                                    sfpes_pkg::st_fin};
  end

  // Status capture, compare outcome and completion pulse
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      status_reg <= 8'h00;
      mismatch_reg <= 1'b0;
      done_reg <= 1'b0;
      rewrite_reg <= 1'b0;
    end
    else
    begin
      done_reg <= state_reg == sfpes_pkg::st_fin;
      if (sh_done && (state_reg == sfpes_pkg::st_poll_rd))
        status_reg <= sh_rx;
      if ((state_reg == sfpes_pkg::st_fin) && (op_reg == sfpes_pkg::cmd_compare))
        mismatch_reg <= status_reg[`SFPES_STAT_COMP_BIT];
      if (wear_taken)
        rewrite_reg <= 1'b1;
      else if (state_reg == sfpes_pkg::st_fin)
        rewrite_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------

  // Serial bit engine
  sfpes_shifter #(
    .SCK_HALF(SCK_HALF)
  ) u_shifter (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(sh_start),
    .tx_byte(sh_tx),
    .done(sh_done),
    .rx_byte(sh_rx),
    .sck(flash_sck),
    .si(flash_si),
    .so(flash_so)
  );

  // Sector refresh scheduler
  sfpes_wear #(
    .INTERVAL(REWRITE_INTERVAL)
  ) u_wear (
    .sys_clk(sys_clk),
    .reset(reset),
    .op_done(wear_op_done),
    .op_page(page_reg),
    .taken(wear_taken),
    .due(wear_due),
    .due_page(wear_page)
  );

  assign busy = state_reg != sfpes_pkg::st_idle;
  assign done = done_reg;
  assign compare_mismatch = mismatch_reg;
  assign status_byte = status_reg;
  assign rewrite_active = rewrite_reg;
  assign flash_cs_n = cs_n_reg;
endmodule // sfpes_host
`default_nettype wire

// file: tb/sfpes_host_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sfpes_host_assertions #(
  parameter int SCK_HALF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Handshakes
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic wr_valid,
  input wire logic wr_ready,
  // Status
  input wire logic busy,
  input wire logic done,
  // Flash pins
  input wire logic flash_cs_n,
  input wire logic flash_sck,
  input wire logic flash_si
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  int hi_cnt;
  // Counts cycles the serial clock has been high
  always_ff @(posedge sys_clk)
  begin
    if (reset || !flash_sck)
      hi_cnt <= 0;
    else
      hi_cnt <= hi_cnt + 1;
  end
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_release;
    $rose(flash_cs_n);
  endsequence
  a_take_busy: assert property (s_take |=> busy)
    else $error("taken command did not raise busy");
  a_busy_refuse: assert property (busy |-> !cmd_ready)
    else $error("command accepted while busy");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_idle: assert property (done |-> !busy)
    else $error("busy still high with done");
  a_idle_deselect: assert property (!busy |-> flash_cs_n && !flash_sck)
    else $error("flash selected or clocked while idle");
  a_sck_in_frame: assert property (flash_sck |-> !flash_cs_n)
    else $error("serial clock high outside a frame");
  a_si_steady: assert property (flash_sck ##1 flash_sck |-> $stable(flash_si))
    else $error("serial data moved while clock high");
  a_sck_half: assert property ($fell(flash_sck) |-> hi_cnt == SCK_HALF)
    else $error("serial clock high time wrong");
  a_wr_gap: assert property (wr_valid && wr_ready |=> !wr_ready)
    else $error("data ready while a byte is shifting");
  a_cs_gap: assert property (s_release |-> flash_cs_n [*8])
    else $error("chip select high time too short");
endmodule // sfpes_host_assertions
`default_nettype wire

// file: tb/sfpes_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfpes_dev_model #(
  parameter int BUSY_CYC = 60
) (
  // Timing clock
  input wire logic clk,
  // Serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so,
  // Compare outcome to report
  input wire logic mismatch
);
  logic [31:0] sh = 32'h0;
  logic [7:0] cur_op = 8'h00;
  logic [23:0] last_addr = 24'h0;
  logic [7:0] last_op = 8'h00;
  logic [8:0] idx = 9'h000;
  logic [7:0] buf_mem [2][264];
  logic comp = 1'b0;
  logic comp_next = 1'b0;
  logic [9:0] rw_page = 10'h000;
  int nbit = 0, nbytes = 0, busy_cnt = 0, ops = 0, viol = 0, rw_count = 0;
  wire logic load = cur_op inside {8'h84, 8'h87, 8'h82, 8'h85};
  wire logic [7:0] stat = {busy_cnt == 0, comp, 6'h14};
  initial so = 1'b0;
  // A falling chip select opens a frame
  always @(negedge cs_n)
    nbit = 0;
  // Opcode, address and data shifted in on rising clock, only while selected
  always @(posedge sck)
  begin
    if (!cs_n)
    begin
      sh = {sh[30:0], si};
      nbit++;
      if (nbit == 8)
        cur_op = sh[7:0];
      if (nbit == 32 && cur_op != 8'h57)
      begin
        last_addr = sh[23:0];
        last_op = cur_op; // Survives the status polls that follow
        idx = sh[8:0];
        nbytes = 0;
      end
      if (nbit > 32 && nbit % 8 == 0 && load)
      begin
        buf_mem[cur_op[0]][idx] = sh[7:0];
        idx = (idx == 9'h107) ? 9'h000 : idx + 9'h001;
        nbytes++;
      end
    end
  end
  // Status bits out after a status opcode, junk otherwise
  always @(negedge sck)
  begin
    if (!cs_n && cur_op == 8'h57 && nbit >= 8)
      so <= stat[7 - (nbit - 8) % 8];
    else
      so <= ~so;
  end
  // Released line toggles; self-timed work counts down
  always @(posedge clk)
  begin
    if (cs_n)
      so <= ~so;
    if (busy_cnt == 1)
      comp = comp_next;
    if (busy_cnt > 0)
      busy_cnt = busy_cnt - 1;
  end
  // Array work starts on chip select rise after a whole header
  always @(posedge cs_n)
  begin
    if (nbit >= 32 && !(cur_op inside {8'h57, 8'h84, 8'h87}))
    begin
      if (busy_cnt > 0)
        viol++;
      ops++;
      busy_cnt = BUSY_CYC;
      if (cur_op inside {8'h60, 8'h61})
        comp_next = mismatch;
      if (cur_op inside {8'h58, 8'h59})
      begin
        rw_count++;
        rw_page = last_addr[18:9];
      end
    end
  end
endmodule // sfpes_dev_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_buffer_two = 1'b0;
  logic wr_valid = 1'b0, wr_last = 1'b0, mismatch = 1'b0, saw_rw = 1'b0;
  sfpes_pkg::sfpes_cmd_t cmd_op = sfpes_pkg::cmd_buf_write;
  logic [9:0] cmd_page_number = 10'h000;
  logic [8:0] cmd_buffer_byte_index = 9'h000;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, wr_ready, busy, done, compare_mismatch, rewrite_active;
  logic flash_cs_n, flash_sck, flash_si, flash_so;
  logic [7:0] status_byte;
  int fails = 0, checked = 0;
  // System clock
  always #5 sys_clk = ~sys_clk;
  // Remember any automatic refresh
  always @(posedge sys_clk)
    if (rewrite_active === 1'b1)
      saw_rw <= 1'b1;
  sfpes_host uut (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_buffer_two(cmd_buffer_two),
    .cmd_page_number(cmd_page_number), .cmd_buffer_byte_index(cmd_buffer_byte_index),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_last(wr_last),
    .busy(busy), .done(done), .compare_mismatch(compare_mismatch),
    .status_byte(status_byte), .rewrite_active(rewrite_active), .flash_cs_n(flash_cs_n),
    .flash_sck(flash_sck), .flash_si(flash_si), .flash_so(flash_so));
  sfpes_dev_model dev (.clk(sys_clk), .cs_n(flash_cs_n), .sck(flash_sck), .si(flash_si),
    .so(flash_so), .mismatch(mismatch));
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Waits for cmd_ready (0), wr_ready (1) or done (2) with a bound
  task automatic wait_for(input int sel);
    int t;
    t = 0;
    forever
    begin
      @(posedge sys_clk);
      if ((sel == 0 ? cmd_ready : sel == 1 ? wr_ready : done) === 1'b1)
        break;
      t++;
      if (t > 20000)
      begin
        check(1'b0, "wait timed out");
        end_sim();
      end
    end
  endtask
  // One command with n data bytes counting up from d, then wait for done
  task automatic run(input sfpes_pkg::sfpes_cmd_t op, input logic b2, input logic [9:0] pg,
    input logic [8:0] ix, input int n, input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_buffer_two <= b2;
    cmd_page_number <= pg;
    cmd_buffer_byte_index <= ix;
    wait_for(0);
    cmd_valid <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      wr_valid <= 1'b1;
      wr_data <= d + 8'(i);
      wr_last <= (i == n - 1);
      wait_for(1);
    end
    wr_valid <= 1'b0;
    wait_for(2);
  endtask
  task automatic s_reset();
    check(cmd_ready === 1'b1 && busy === 1'b0 && flash_cs_n === 1'b1, "idle after reset");
  endtask
  // Every command on both buffers, top page, load starting two bytes before the end
  task automatic s_opcodes();
    logic [7:0] opc [18] = '{8'h84, 8'h87, 8'h83, 8'h86, 8'h88, 8'h89, 8'h81, 8'h81, 8'h50,
      8'h50, 8'h82, 8'h85, 8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
    logic [23:0] exp;
    int ops0;
    for (int k = 0; k < 18; k++)
    begin
      if (k / 2 == 2)
        run(sfpes_pkg::cmd_page_erase, 1'b0, 10'h3ff, 9'h000, 0, 8'h00);
      ops0 = dev.ops;
      run(sfpes_pkg::sfpes_cmd_t'(k / 2), k[0], 10'h3ff, 9'h106,
        (k < 2 || k / 2 == 5) ? 3 : 0, 8'(k * 16));
      exp = (k < 2) ? 24'h000106 : (k / 2 == 4) ? 24'h07f000 : (k / 2 == 5) ? 24'h07ff06
        : 24'h07fe00;
      check(dev.last_op === opc[k], "opcode");
      check(dev.last_addr === exp, "address field");
      check(dev.ops == ops0 + (k < 2 ? 0 : 1), "array start count");
      if (k < 2 || k / 2 == 5)
        check(dev.buf_mem[k % 2][0] === 8'(k * 16 + 2) && dev.nbytes == 3, "load");
    end
  endtask
  // Compare differing then equal
  task automatic s_compare();
    for (int m = 1; m >= 0; m--)
    begin
      mismatch <= m[0];
      run(sfpes_pkg::cmd_compare, 1'b0, 10'h005, 9'h000, 0, 8'h00);
      check(compare_mismatch === m[0] && status_byte[6] === m[0], "compare");
      check(status_byte[7] === 1'b1 && dev.busy_cnt == 0, "ready at done");
    end
    check(dev.viol == 0, "array command while device busy");
  endtask
  // Repeated erases in the smallest sector must bring one refresh rewrite there
  task automatic s_wear();
    int rw0;
    rw0 = dev.rw_count;
    repeat (18)
      run(sfpes_pkg::cmd_page_erase, 1'b0, 10'h003, 9'h000, 0, 8'h00);
    run(sfpes_pkg::cmd_compare, 1'b0, 10'h003, 9'h000, 0, 8'h00);
    check(dev.rw_count == rw0 + 1 && dev.rw_page < 10'h008 && saw_rw === 1'b1, "refresh");
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    s_reset();
    s_opcodes();
    s_compare();
    s_wear();
    end_sim();
  end
endmodule // testbench
bind sfpes_host sfpes_host_assertions #(.SCK_HALF(SCK_HALF)) chk (.sys_clk(sys_clk),
  .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .busy(busy), .done(done), .flash_cs_n(flash_cs_n),
  .flash_sck(flash_sck), .flash_si(flash_si));
`default_nettype wire
